// ---- bert_pkg.sv ----
// Purpose: Shared constants and types for the bit error-rate tester
// Assumes: One clock; line bits advance on a one-cycle bit enable
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus
//
// Overview of operation
// - PRBS/QRSS: shift 32 line bits into generator, then 32 matches give sync
// - In sync, six or more mismatches within a 64-bit window restart sync
// - A configuration bit disables automatic re-synchronization
// - Repetitive mode: search every bit position, then 32 matches give sync
// - Out-of-sync flag is high exactly while the state is not sync
// - Each bit compared; mismatch counts error and bit, match counts bit only
// - Bit and error counters hold while out of sync
// - Transmit generator is 32-bit shift register, feedback enters bit 1, is output
// - PRBS feedback is bit n xor bit y; repetitive feedback is bit n
// - QRSS feedback is bits 17 xor 20; output forced one after 14 zeros
// - PRBS/QRSS feedback forced one when bits 1 to 31 are zero
// - Pattern load presets the transmit generator with the seed first
// - Periodic error insertion at one per ten-to-the-n bits, n 1 to 7 or off
// - Single errors from register write or manual pin, source selectable
// - Optional inversion of the outgoing pattern stream
// - Patterns load on zero-to-one transitions of the load bits
// - Snapshot request copies counters to readable registers and clears them
// - Error-seen flag is one while the error counter is nonzero
package bert_pkg;
  localparam int ADDR_W = 8;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_SEED = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_BITS = 8'h10;
  localparam logic [7:0] OFS_ERRS = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_TXLD = 0;
  localparam int CTL_RXLD = 1;
  localparam int CTL_SNAP = 2;
  localparam int CTL_SERR = 3;
  localparam int CFG_LEN = 0;
  localparam int CFG_TAP = 8;
  localparam int CFG_REP = 16;
  localparam int CFG_QRSS = 17;
  localparam int CFG_NORS = 18;
  localparam int CFG_INV = 19;
  localparam int CFG_PIN = 20;
  localparam int CFG_RATE = 21;
  localparam int ST_OOS = 0;
  localparam int ST_ERR = 1;
  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SEED_RST = 32'hFFFF_FFFF;
  localparam logic [5:0] SYNC_BITS = 6'h1F;
  localparam logic [5:0] WIN_LAST = 6'h3F;
  localparam logic [5:0] ERR_LIMIT = 6'h06;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_CHECK = 2'b01,
    ST_SYNC = 2'b11,
    ST_SEARCH = 2'b10
  } bert_state_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } bert_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } bert_axi_rsp_t;

  // Bits between periodic errors, ten to the n
  function automatic logic [23:0] bert_decade(input logic [2:0] n);
    case (n)
      3'd1: bert_decade = 24'd10;
      3'd2: bert_decade = 24'd100;
      3'd3: bert_decade = 24'd1000;
      3'd4: bert_decade = 24'd10000;
      3'd5: bert_decade = 24'd100000;
      3'd6: bert_decade = 24'd1000000;
      default: bert_decade = 24'd10000000;
    endcase
  endfunction
endpackage

// ---- bert_top.sv ----
// Purpose: Bit error-rate tester: pattern generator, error insertion, receive monitor
// Assumes: line_bit_en marks each line bit; rx_line_data is on sys_clk
// Notes: Manual error pin is asynchronous and is synchronised here
`timescale 1ns/1ps
module bert_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire bert_pkg::bert_axi_req_t axi_req,
  output bert_pkg::bert_axi_rsp_t axi_rsp,
  input wire logic line_bit_en,
  input wire logic rx_line_data,
  input wire logic manual_error_insert_input,
  output logic tx_line_data,
  output logic out_of_sync_flag,
  output logic error_seen_flag
);
  // ----------------------------------------
  // Register file and AXI4-Lite slave
  // ----------------------------------------
  logic [31:0] ctrl, cfg, seed, bits_held, errs_held, rdata;
  logic [31:0] next_ctrl, next_cfg, next_seed, wval;
  logic aw_got, w_got, bvalid, rvalid, next_aw_got, next_w_got, next_bvalid, next_rvalid;
  logic [7:0] awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata, next_rdata;
  logic [3:0] wstrb, next_wstrb;
  logic [1:0] bresp, rresp, next_bresp, next_rresp;
  logic do_wr, tx_load, rx_load, snap, sw_err;
  logic [31:0] bit_cnt, err_cnt;

  assign do_wr = aw_got && w_got && !bvalid;
  assign axi_rsp.awready = !aw_got;
  assign axi_rsp.wready = !w_got;
  assign axi_rsp.bvalid = bvalid;
  assign axi_rsp.bresp = bresp;
  assign axi_rsp.arready = !rvalid;
  assign axi_rsp.rvalid = rvalid;
  assign axi_rsp.rdata = rdata;
  assign axi_rsp.rresp = rresp;

  // Byte-lane merge helper
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // Rising edges of the control bits act as strobes
  assign wval = merge(ctrl, wdata, wstrb);
  assign tx_load = do_wr && awaddr == bert_pkg::OFS_CTRL && wval[bert_pkg::CTL_TXLD]
    && !ctrl[bert_pkg::CTL_TXLD];
  assign rx_load = do_wr && awaddr == bert_pkg::OFS_CTRL && wval[bert_pkg::CTL_RXLD]
    && !ctrl[bert_pkg::CTL_RXLD];
  assign snap = do_wr && awaddr == bert_pkg::OFS_CTRL && wval[bert_pkg::CTL_SNAP]
    && !ctrl[bert_pkg::CTL_SNAP];
  assign sw_err = do_wr && awaddr == bert_pkg::OFS_CTRL && wval[bert_pkg::CTL_SERR]
    && !ctrl[bert_pkg::CTL_SERR];

  // Bus next-state
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctrl = ctrl;
    next_cfg = cfg;
    next_seed = seed;
    if (axi_req.awvalid && !aw_got) begin
      next_aw_got = 1'b1;
      next_awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !w_got) begin
      next_w_got = 1'b1;
      next_wdata = axi_req.wdata;
      next_wstrb = axi_req.wstrb;
    end
    if (do_wr) begin
      next_bvalid = 1'b1;
      next_bresp = bert_pkg::RESP_OK;
      case (awaddr)
        bert_pkg::OFS_CTRL: next_ctrl = {28'h000_0000, wval[3:0]};
        bert_pkg::OFS_CFG: next_cfg = merge(cfg, wdata, wstrb);
        bert_pkg::OFS_SEED: next_seed = merge(seed, wdata, wstrb);
        bert_pkg::OFS_STAT, bert_pkg::OFS_BITS, bert_pkg::OFS_ERRS: ;
        default: next_bresp = bert_pkg::RESP_ERR;
      endcase
    end
    if (bvalid && axi_req.bready) begin
      next_bvalid = 1'b0;
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
    end
    if (rvalid && axi_req.rready) begin
      next_rvalid = 1'b0;
    end
    if (axi_req.arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = bert_pkg::RESP_OK;
      case (axi_req.araddr)
        bert_pkg::OFS_CTRL: next_rdata = ctrl;
        bert_pkg::OFS_CFG: next_rdata = cfg;
        bert_pkg::OFS_SEED: next_rdata = seed;
        bert_pkg::OFS_STAT: next_rdata = {30'h0000_0000, error_seen_flag, out_of_sync_flag};
        bert_pkg::OFS_BITS: next_rdata = bits_held;
        bert_pkg::OFS_ERRS: next_rdata = errs_held;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = bert_pkg::RESP_ERR;
        end
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
      ctrl <= 32'h0000_0000;
      cfg <= bert_pkg::CFG_RST;
      seed <= bert_pkg::SEED_RST;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      seed <= next_seed;
    end
  end

  // ----------------------------------------
  // Pattern generator feedback
  // ----------------------------------------
  logic [4:0] len, tap;
  logic rep, qrss, no_resync, invert, pin_src;
  logic [2:0] rate;
  assign len = cfg[bert_pkg::CFG_LEN +: 5];
  assign tap = cfg[bert_pkg::CFG_TAP +: 5];
  assign rep = cfg[bert_pkg::CFG_REP];
  assign qrss = cfg[bert_pkg::CFG_QRSS];
  assign no_resync = cfg[bert_pkg::CFG_NORS];
  assign invert = cfg[bert_pkg::CFG_INV];
  assign pin_src = cfg[bert_pkg::CFG_PIN];
  assign rate = cfg[bert_pkg::CFG_RATE +: 3];

  // Feedback shared by both generators
  function automatic logic gen_fb(input logic [31:0] sr);
    if (rep) begin
      gen_fb = sr[len];
    end else if (!(|sr[30:0])) begin
      gen_fb = 1'b1;
    end else if (qrss) begin
      gen_fb = sr[16] ^ sr[19];
    end else begin
      gen_fb = sr[len] ^ sr[tap];
    end
  endfunction

  // Output is the feedback, QRSS zero run forced high
  function automatic logic gen_out(input logic [31:0] sr);
    gen_out = (qrss && !rep && !(|sr[13:0])) ? 1'b1 : gen_fb(sr);
  endfunction

  // ----------------------------------------
  // Transmit generator and error insertion
  // ----------------------------------------
  logic [31:0] tx_sr, next_tx_sr;
  logic [23:0] rate_cnt, next_rate_cnt;
  logic pin_s1, pin_s2, pin_d, err_pend, next_err_pend, next_tx_data, rate_hit, req;
  assign rate_hit = rate != 3'd0 && rate_cnt == bert_pkg::bert_decade(rate) - 24'd1;
  assign req = pin_src ? (pin_s2 && !pin_d) : sw_err;

  always_comb begin
    next_tx_sr = tx_sr;
    next_rate_cnt = rate_cnt;
    next_tx_data = tx_line_data;
    next_err_pend = err_pend;
    if (tx_load) begin
      next_tx_sr = seed;
    end else if (line_bit_en) begin
      next_tx_sr = {tx_sr[30:0], gen_fb(tx_sr)};
      next_rate_cnt = (rate_hit || rate == 3'd0) ? 24'd0 : rate_cnt + 24'd1;
      next_tx_data = gen_out(tx_sr) ^ err_pend ^ rate_hit ^ invert;
      next_err_pend = 1'b0;
    end
    if (req) begin
      next_err_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_sr <= 32'h0000_0000;
      rate_cnt <= 24'h00_0000;
      tx_line_data <= 1'b0;
      err_pend <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d <= 1'b0;
    end else begin
      tx_sr <= next_tx_sr;
      rate_cnt <= next_rate_cnt;
      tx_line_data <= next_tx_data;
      err_pend <= next_err_pend;
      pin_s1 <= manual_error_insert_input;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // ----------------------------------------
  // Receive synchronizer and monitor
  // ----------------------------------------
  bert_pkg::bert_state_t state, next_state;
  logic [31:0] rx_sr, next_rx_sr, mask, next_bit_cnt, next_err_cnt, shifted;
  logic [5:0] cnt, next_cnt, win_err, next_win_err;
  logic miss, hit;
  // Receive compare; a process so config changes re-evaluate it
  always_comb begin
    miss = rx_line_data != gen_out(rx_sr);
  end
  assign shifted = {rx_sr[30:0], rx_line_data};
  assign mask = 32'hFFFF_FFFF >> (5'd31 - len);
  assign hit = (shifted & mask) == (seed & mask);
  assign out_of_sync_flag = state != bert_pkg::ST_SYNC;
  assign error_seen_flag = err_cnt != 32'h0000_0000;

  always_comb begin
    next_state = state;
    next_rx_sr = rx_sr;
    next_cnt = cnt;
    next_win_err = win_err;
    next_bit_cnt = snap ? 32'h0000_0000 : bit_cnt;
    next_err_cnt = snap ? 32'h0000_0000 : err_cnt;
    if (rx_load) begin
      next_state = rep ? bert_pkg::ST_SEARCH : bert_pkg::ST_LOAD;
      next_cnt = 6'd0;
    end else if (line_bit_en) begin
      case (state)
        bert_pkg::ST_LOAD: begin
          next_rx_sr = shifted;
          next_cnt = cnt + 6'd1;
          if (cnt == bert_pkg::SYNC_BITS) begin
            next_state = bert_pkg::ST_CHECK;
            next_cnt = 6'd0;
          end
        end
        bert_pkg::ST_SEARCH: begin
          next_rx_sr = shifted;
          next_cnt = 6'd0;
          if (hit) begin
            next_state = bert_pkg::ST_CHECK;
          end
        end
        bert_pkg::ST_CHECK: begin
          next_rx_sr = {rx_sr[30:0], gen_fb(rx_sr)};
          next_cnt = cnt + 6'd1;
          if (miss) begin
            next_state = rep ? bert_pkg::ST_SEARCH : bert_pkg::ST_LOAD;
            next_cnt = 6'd0;
          end else if (cnt == bert_pkg::SYNC_BITS) begin
            next_state = bert_pkg::ST_SYNC;
            next_cnt = 6'd0;
            next_win_err = 6'd0;
          end
        end
        bert_pkg::ST_SYNC: begin
          next_rx_sr = {rx_sr[30:0], gen_fb(rx_sr)};
          next_cnt = cnt + 6'd1;
          next_win_err = (cnt == bert_pkg::WIN_LAST) ? 6'd0 : win_err + {5'd0, miss};
          next_bit_cnt = next_bit_cnt + 32'd1;
          next_err_cnt = next_err_cnt + {31'd0, miss};
          if (!no_resync && win_err + {5'd0, miss} >= bert_pkg::ERR_LIMIT) begin
            next_state = rep ? bert_pkg::ST_SEARCH : bert_pkg::ST_LOAD;
            next_cnt = 6'd0;
          end
        end
        default: next_state = bert_pkg::ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= bert_pkg::ST_LOAD;
      rx_sr <= 32'h0000_0000;
      cnt <= 6'd0;
      win_err <= 6'd0;
      bit_cnt <= 32'h0000_0000;
      err_cnt <= 32'h0000_0000;
      bits_held <= 32'h0000_0000;
      errs_held <= 32'h0000_0000;
    end else begin
      state <= next_state;
      rx_sr <= next_rx_sr;
      cnt <= next_cnt;
      win_err <= next_win_err;
      bit_cnt <= next_bit_cnt;
      err_cnt <= next_err_cnt;
      if (snap) begin
        bits_held <= bit_cnt;
        errs_held <= err_cnt;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_check_done;
    state == bert_pkg::ST_CHECK && line_bit_en && !rx_load && !miss && cnt == 6'd31;
  endsequence
  chk_sync_entry: assert property (s_check_done |=> state == bert_pkg::ST_SYNC)
    else $error("check pass did not reach sync");
  chk_sync_source: assert property ($rose(state == bert_pkg::ST_SYNC) |->
    $past(state) == bert_pkg::ST_CHECK)
    else $error("sync entered without check");
  chk_resync_drop: assert property (state == bert_pkg::ST_SYNC && line_bit_en && !rx_load
    && !no_resync && win_err == 6'd5 && miss |=> state != bert_pkg::ST_SYNC)
    else $error("sixth error kept sync");
  chk_resync_off: assert property (state == bert_pkg::ST_SYNC && no_resync && !rx_load
    |=> state == bert_pkg::ST_SYNC)
    else $error("sync lost with resync off");
  chk_oos_flag: assert property (out_of_sync_flag |-> state != bert_pkg::ST_SYNC)
    else $error("flag disagrees with state");
  chk_bit_count: assert property (state == bert_pkg::ST_SYNC && line_bit_en && !rx_load
    && !snap |=> bit_cnt == $past(bit_cnt) + 32'd1 && err_cnt == $past(err_cnt)
    + {31'd0, $past(miss)})
    else $error("counters did not advance");
  chk_oos_hold: assert property (state != bert_pkg::ST_SYNC && !snap
    |=> $stable(bit_cnt) && $stable(err_cnt))
    else $error("counter moved out of sync");
  sequence s_loaded;
    tx_load ##1 tx_sr == $past(seed);
  endsequence
  chk_tx_load: assert property (tx_load |-> s_loaded)
    else $error("seed not preset");
  chk_tx_shift: assert property (line_bit_en && !tx_load
    |=> tx_sr[31:1] == $past(tx_sr[30:0]))
    else $error("generator did not shift");
  chk_zero_guard: assert property (line_bit_en && !tx_load && !rep && tx_sr[30:0] == 31'd0
    |=> tx_sr[0])
    else $error("all-zero lockup");
  chk_snapshot: assert property (snap |=> bits_held == $past(bit_cnt)
    && errs_held == $past(err_cnt))
    else $error("snapshot wrong");
endmodule // bert_top

// ---- bert_line_model.sv ----
// Purpose: Line loopback partner for the bit error-rate tester
// Assumes: One line bit every four sys_clk cycles
// Notes: corrupt inverts looped bits; run gates the bit pulses
`timescale 1ns/1ps
module bert_line_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic corrupt,
  input wire logic tx_line_data,
  output logic line_bit_en,
  output logic rx_line_data
);
  logic [1:0] phase;
  logic held;
  // ----------------------------------------
  // Bit pacing and loopback
  // ----------------------------------------
  // Transmit bit captured once settled, returned on the next bit pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      line_bit_en <= 1'b0;
      held <= 1'b0;
      rx_line_data <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      line_bit_en <= (phase == 2'h3) && run;
      if (phase == 2'h2) begin
        held <= tx_line_data;
      end
      if (phase == 2'h3) begin
        rx_line_data <= held ^ corrupt; // Deliberate line errors
      end
    end
  end
endmodule // bert_line_model

// ---- bit_error_rate_tester_test.sv ----
// Purpose: Self-checking bench for the bit error-rate tester
// Assumes: Loopback partner closes the line path
// Notes: Line is paused around register accesses so counts are exact
`timescale 1ns/1ps
module bit_error_rate_tester_test;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic [1:0] r;} bert_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  bert_pkg::bert_axi_req_t axi_req = '0;
  bert_pkg::bert_axi_rsp_t axi_rsp;
  logic line_bit_en, rx_line_data, tx_line_data, out_of_sync_flag, error_seen_flag;
  logic pin = 1'b0;
  logic run = 1'b0;
  logic corrupt = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int nb, zr, zmax, bad;
  logic [1:0] resp;
  logic [31:0] rd;
  logic bits [0:255];
  bert_row_t rows [0:9] = '{
    '{bert_pkg::OFS_CFG, 1'b0, 32'h0000_0000, bert_pkg::CFG_RST, bert_pkg::RESP_OK},
    '{bert_pkg::OFS_SEED, 1'b0, 32'h0000_0000, bert_pkg::SEED_RST, bert_pkg::RESP_OK},
    '{bert_pkg::OFS_STAT, 1'b0, 32'h0000_0000, 32'h0000_0001, bert_pkg::RESP_OK},
    '{bert_pkg::OFS_ERRS, 1'b0, 32'h0000_0000, 32'h0000_0000, bert_pkg::RESP_OK},
    '{bert_pkg::OFS_SEED, 1'b1, 32'h0000_1234, 32'h0000_0000, bert_pkg::RESP_OK},
    '{bert_pkg::OFS_SEED, 1'b0, 32'h0000_0000, 32'h0000_1234, bert_pkg::RESP_OK},
    '{bert_pkg::OFS_BITS, 1'b1, 32'h0000_0005, 32'h0000_0000, bert_pkg::RESP_OK},
    '{bert_pkg::OFS_BITS, 1'b0, 32'h0000_0000, 32'h0000_0000, bert_pkg::RESP_OK},
    '{8'h18, 1'b0, 32'h0000_0000, 32'h0000_0000, bert_pkg::RESP_ERR},
    '{8'h18, 1'b1, 32'h0000_0001, 32'h0000_0000, bert_pkg::RESP_ERR}};

  // ----------------------------------------
  // Clock, parts and watchdog
  // ----------------------------------------
  always #50 sys_clk = ~sys_clk;

  bert_top dut (.sys_clk(sys_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .line_bit_en(line_bit_en), .rx_line_data(rx_line_data),
    .manual_error_insert_input(pin), .tx_line_data(tx_line_data),
    .out_of_sync_flag(out_of_sync_flag), .error_seen_flag(error_seen_flag));

  bert_line_model partner (.sys_clk(sys_clk), .rst(rst), .run(run), .corrupt(corrupt),
    .tx_line_data(tx_line_data), .line_bit_en(line_bit_en), .rx_line_data(rx_line_data));

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task ok(input logic c);
    check({31'h0000_0000, c}, 32'h0000_0001);
  endtask

  task complete_run;
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // AXI4-Lite write, handshakes judged at the coming rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge sys_clk);
    axi_req.awaddr <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (!b) begin
      @(negedge sys_clk);
      aw = axi_req.awvalid && axi_rsp.awready;
      w = axi_req.wvalid && axi_rsp.wready;
      b = axi_rsp.bvalid;
      resp = axi_rsp.bresp;
      @(posedge sys_clk);
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
    end
    axi_req.bready <= 1'b0;
  endtask

  // AXI4-Lite read
  task rdr(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge sys_clk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    while (!r) begin
      @(negedge sys_clk);
      ar = axi_req.arvalid && axi_rsp.arready;
      r = axi_rsp.rvalid;
      rd = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      @(posedge sys_clk);
      if (ar) axi_req.arvalid <= 1'b0;
    end
    axi_req.rready <= 1'b0;
  endtask

  task pulse(input int b);
    wr(bert_pkg::OFS_CTRL, 32'h0000_0001 << b);
    wr(bert_pkg::OFS_CTRL, 32'h0000_0000);
  endtask

  task snap_read(input logic [31:0] eb, input logic [31:0] ee);
    pulse(bert_pkg::CTL_SNAP);
    rdr(bert_pkg::OFS_BITS);
    check(rd, eb);
    rdr(bert_pkg::OFS_ERRS);
    check(rd, ee);
  endtask

  // Config, seed, then load both generators together
  task load(input logic [31:0] c, input logic [31:0] s);
    wr(bert_pkg::OFS_CFG, c);
    wr(bert_pkg::OFS_SEED, s);
    wr(bert_pkg::OFS_CTRL, 32'h0000_0003);
    wr(bert_pkg::OFS_CTRL, 32'h0000_0000);
  endtask

  // Runs the line for n bits; grab also records transmitted bits
  task run_bits(input int n, input logic grab);
    int k;
    k = 0;
    @(posedge sys_clk);
    run <= 1'b1;
    while (k < n) begin
      @(negedge sys_clk);
      if (line_bit_en) begin
        @(negedge sys_clk);
        if (grab) bits[k] = tx_line_data;
        k++;
      end
    end
    @(posedge sys_clk);
    run <= 1'b0;
  endtask

  // Runs the line until the sync flag reaches want, counting bits
  task wait_oos(input logic want);
    nb = 0;
    @(posedge sys_clk);
    run <= 1'b1;
    while (out_of_sync_flag !== want && nb < 200) begin
      @(negedge sys_clk);
      if (line_bit_en) nb++;
    end
    @(posedge sys_clk);
    run <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    ok(out_of_sync_flag === 1'b1);
    ok(error_seen_flag === 1'b0);
    // Register table rows
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rdr(rows[i].a);
        check(rd, rows[i].e);
      end
      check({30'h0000_0000, resp}, {30'h0000_0000, rows[i].r});
    end
    // Repetitive length 8: output must be a rotation of the seed
    load(32'h0001_0007, 32'h0000_001D);
    run_bits(20, 1'b1);
    bad = 1;
    for (int r = 0; r < 8; r++) begin
      zr = 0;
      for (int i = 2; i < 18; i++) zr += (bits[i] !== 1'(8'h1D >> ((r + 24 - i) % 8)));
      if (zr == 0) bad = 0;
    end
    check(bad, 0);
    wait_oos(1'b0);
    ok(nb + 20 >= 33 && nb + 20 <= 48);
    // Inversion off and on with an all-ones pattern
    for (int i = 0; i < 2; i++) begin
      load(32'h0001_0000 | (i << 19), 32'h0000_0001);
      run_bits(8, 1'b1);
      for (int k = 0; k < 8; k++) check(bits[k], i == 0);
    end
    // QRSS: no run of more than 14 zeros
    load(32'h0002_0000, 32'h0000_0000);
    run_bits(200, 1'b1);
    zr = 0;
    zmax = 0;
    foreach (bits[k]) if (k < 200) begin
      zr = bits[k] ? 0 : zr + 1;
      if (zr > zmax) zmax = zr;
    end
    ok(zmax <= 14);
    // PRBS 2^9-1: recurrence on the line, then receive sync timing
    load(32'h0000_0408, bert_pkg::SEED_RST);
    run_bits(48, 1'b1);
    bad = 0;
    for (int t = 12; t < 48; t++) bad += (bits[t] !== (bits[t - 9] ^ bits[t - 5]));
    check(bad, 0);
    wait_oos(1'b0);
    ok(nb + 48 >= 64 && nb + 48 <= 66);
    ok(out_of_sync_flag === 1'b0);
    pulse(bert_pkg::CTL_SNAP);
    run_bits(100, 1'b0);
    snap_read(100, 0);
    // Software single error
    pulse(bert_pkg::CTL_SERR);
    run_bits(20, 1'b0);
    ok(error_seen_flag === 1'b1);
    snap_read(20, 1);
    ok(error_seen_flag === 1'b0);
    // Pin pulse with pin source, then with register source
    for (int j = 0; j < 2; j++) begin
      wr(bert_pkg::OFS_CFG, (j == 0) ? 32'h0010_0408 : 32'h0000_0408);
      @(posedge sys_clk);
      pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      run_bits(20, 1'b0);
      snap_read(20, (j == 0) ? 1 : 0);
    end
    // Rate 1 in 10 with resync disabled
    wr(bert_pkg::OFS_CFG, 32'h0024_0408);
    pulse(bert_pkg::CTL_SNAP);
    run_bits(101, 1'b0);
    snap_read(101, 10);
    ok(out_of_sync_flag === 1'b0);
    // Error burst with resync disabled stays in sync
    wr(bert_pkg::OFS_CFG, 32'h0004_0408);
    pulse(bert_pkg::CTL_SNAP);
    corrupt <= 1'b1;
    run_bits(16, 1'b0);
    ok(out_of_sync_flag === 1'b0);
    snap_read(16, 16);
    // Clean bits past a window boundary so the window starts empty
    corrupt <= 1'b0;
    run_bits(64, 1'b0);
    // Resync enabled: burst drops sync, counters then hold
    wr(bert_pkg::OFS_CFG, 32'h0000_0408);
    corrupt <= 1'b1;
    wait_oos(1'b1);
    ok(nb >= 6 && nb <= 70);
    pulse(bert_pkg::CTL_SNAP);
    run_bits(50, 1'b0);
    snap_read(0, 0);
    rdr(bert_pkg::OFS_STAT);
    check(rd, 32'h0000_0001);
    // Second reset mid-run
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ok(out_of_sync_flag === 1'b1 && tx_line_data === 1'b0);
    complete_run();
  end
endmodule // bit_error_rate_tester_test
